// ### logic/acmc_route.sv
// analog switch steering for the converter core input
// assumes the switches settle within a cycle of their control changing
`timescale 1ns/100ps
module acmc_route (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cal_en,
  input wire logic test_en,
  input wire logic bridge,
  input wire logic pol,
  output acmc_pkg::acmc_route_t route_q
);
  import acmc_pkg::*;

  // ***************************************************
  // decode
  // ***************************************************
  acmc_route_t route_d;
  // calibration wins over self-test if software breaks the pairing ban
  assign route_d.mux_connect = !cal_en;
  assign route_d.ref_to_core = cal_en;
  assign route_d.ref_full = cal_en & bridge;
  assign route_d.ref_high = cal_en & pol;
  assign route_d.test_inject = test_en & !cal_en;
  // polarity is dead when neither mode is on
  assign route_d.test_high = test_en & !cal_en & pol;

  // registered so the switches never see a decode glitch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      route_q <= '{mux_connect: 1'b1, default: 1'b0};
    end else begin
      route_q <= route_d;
    end
  end
endmodule

// ### logic/acmc_seq.sv
// conversion sequencer: starts the core and waits for its end pulse
// assumes the core answers every start with one end-of-conversion pulse
`timescale 1ns/100ps
module acmc_seq (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run_en,
  input wire logic clk_stop,
  input wire logic ref_req,
  input wire logic in_req,
  input wire logic core_eoc,
  output logic core_start_q,
  output logic ref_done,
  output logic in_done,
  output acmc_pkg::acmc_seq_state_t state_q
);
  import acmc_pkg::*;

  // ***************************************************
  // next state
  // ***************************************************
  acmc_seq_state_t state_d;
  logic go_ref;
  logic go_in;
  logic halt;

  // stopped clocks or a cleared run enable park the machine
  assign halt = !run_en | clk_stop;
  assign go_ref = ref_req & !halt;
  assign go_in = in_req & !ref_req & !halt;
  assign ref_done = (state_q == ACMC_SEQ_REF) & core_eoc;
  assign in_done = (state_q == ACMC_SEQ_INPUT) & core_eoc;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ACMC_SEQ_IDLE: begin
        if (go_ref) begin
          state_d = ACMC_SEQ_REF;
        end else if (go_in) begin
          state_d = ACMC_SEQ_INPUT;
        end
      end
      ACMC_SEQ_REF: begin
        if (halt || core_eoc) begin
          state_d = ACMC_SEQ_IDLE;
        end
      end
      ACMC_SEQ_INPUT: begin
        if (halt || core_eoc) begin
          state_d = ACMC_SEQ_IDLE;
        end
      end
      default: begin
        state_d = ACMC_SEQ_IDLE;
      end
    endcase
  end

  // start pulse lasts one cycle, on leaving idle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ACMC_SEQ_IDLE;
      core_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      core_start_q <= (state_q == ACMC_SEQ_IDLE) & (go_ref | go_in);
    end
  end
endmodule

// ### logic/acmc_top.sv
// converter mode control: control register one, the channel select
// registers, a status word and the avalon slave that reaches them
// assumes an avalon-mm master on mclk and a core that pulses
// core_eoc once per conversion it was started for
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module acmc_top (
  input wire logic mclk,
  input wire logic nrst,
  input acmc_pkg::acmc_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire logic core_eoc,
  input wire logic conv_event,
  output logic core_start,
  output acmc_pkg::acmc_route_t route,
  output logic clock_stop
);
  import acmc_pkg::*;

  // ***************************************************
  // state read across sections
  // ***************************************************
  // declared ahead: the decode and merge logic read these before
  // the control and sequencing sections that drive them
  logic clock_stop_q;
  logic [15:0] ctrl_w;
  logic ref_done;
  logic in_done;

  // ***************************************************
  // bus handshake
  // ***************************************************
  logic wait_q;
  logic wait_d;
  logic pend;
  logic take;
  logic wr_take;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // one wait cycle, then the answer: keeps read data registered
  assign pend = av_req.read | av_req.write;
  assign wait_d = wait_q ? !pend : 1'b1;
  assign take = pend & !wait_q;
  assign wr_take = take & av_req.write;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // ***************************************************
  // address decode
  // ***************************************************
  function automatic logic hit(input logic [ACMC_AW-1:0] a,
                               input logic [7:0] ofs);
    hit = (a[ACMC_AW-1:2] == ofs[7:2]);
  endfunction

  logic sel_ctrl;
  logic sel_stat;
  logic sel_evt;
  logic sel_g1;
  logic sel_g2;
  logic pdn_block;

  // power-down fences everything but control one, which must stay
  // reachable or the power-down bit could never be cleared again
  assign pdn_block = clock_stop_q;
  assign sel_ctrl = hit(av_req.address, ACMC_OFS_CTRL_ONE);
  assign sel_stat = hit(av_req.address, ACMC_OFS_STATUS) & !pdn_block;
  assign sel_evt = hit(av_req.address, ACMC_OFS_EVT_SEL) & !pdn_block;
  assign sel_g1 = hit(av_req.address, ACMC_OFS_G1_SEL) & !pdn_block;
  assign sel_g2 = hit(av_req.address, ACMC_OFS_G2_SEL) & !pdn_block;

  // ***************************************************
  // byte lane merge
  // ***************************************************
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    merge[7:0] = be[0] ? wd[7:0] : old[7:0];
    merge[15:8] = be[1] ? wd[15:8] : old[15:8];
  endfunction

  logic [15:0] wmask_ctrl;
  logic [15:0] ctrl_new;
  logic wr_ctrl;
  logic [31:0] wd;
  logic [3:0] be;

  assign wd = av_req.writedata;
  assign be = av_req.byteenable;
  assign wr_ctrl = wr_take & sel_ctrl;
  assign ctrl_new = merge(ctrl_w, wd, be);

  // ***************************************************
  // control register one
  // ***************************************************
  logic cal_en_q;
  logic reference_convert_start_q;
  logic bridge_q;
  logic pol_q;
  logic test_q;
  logic run_q;
  logic reference_convert_start_set;
  logic reference_convert_start_clr;

  // reserved pair 7:6, bit 14 and the fields kept out of this block
  // read zero and keep no state, so a write to them is simply lost
  always_comb begin
    ctrl_w = ACMC_RST_REG;
    ctrl_w[ACMC_BIT_CAL_EN] = cal_en_q;
    ctrl_w[ACMC_BIT_REFERENCE_CONVERT_START] = reference_convert_start_q;
    ctrl_w[ACMC_BIT_BRIDGE] = bridge_q;
    ctrl_w[ACMC_BIT_POL] = pol_q;
    ctrl_w[ACMC_BIT_TEST] = test_q;
    ctrl_w[ACMC_BIT_STOP] = clock_stop_q;
    ctrl_w[ACMC_BIT_RUN] = run_q;
  end

  // plain read/write fields
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cal_en_q <= ACMC_RST_REG[ACMC_BIT_CAL_EN];
      bridge_q <= ACMC_RST_REG[ACMC_BIT_BRIDGE];
      pol_q <= ACMC_RST_REG[ACMC_BIT_POL];
      test_q <= ACMC_RST_REG[ACMC_BIT_TEST];
      clock_stop_q <= ACMC_RST_REG[ACMC_BIT_STOP];
      run_q <= ACMC_RST_REG[ACMC_BIT_RUN];
    end else if (wr_ctrl) begin
      cal_en_q <= ctrl_new[ACMC_BIT_CAL_EN];
      bridge_q <= ctrl_new[ACMC_BIT_BRIDGE];
      pol_q <= ctrl_new[ACMC_BIT_POL];
      test_q <= ctrl_new[ACMC_BIT_TEST];
      clock_stop_q <= ctrl_new[ACMC_BIT_STOP];
      run_q <= ctrl_new[ACMC_BIT_RUN];
    end
  end

  // start bit: a written 1 sets it, a written 0 does nothing, and
  // only the end of the reference conversion clears it; set wins
  assign reference_convert_start_set = wr_ctrl & be[1] & wd[ACMC_BIT_REFERENCE_CONVERT_START];
  assign reference_convert_start_clr = ref_done;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reference_convert_start_q <= ACMC_RST_REG[ACMC_BIT_REFERENCE_CONVERT_START];
    end else if (reference_convert_start_set) begin
      reference_convert_start_q <= 1'b1;
    end else if (reference_convert_start_clr) begin
      reference_convert_start_q <= 1'b0;
    end
  end

  // ***************************************************
  // channel select registers
  // ***************************************************
  logic [15:0] evt_sel_q;
  logic [15:0] g1_sel_q;
  logic [15:0] g2_sel_q;
  logic wr_evt;
  logic wr_g1;
  logic wr_g2;

  assign wr_evt = wr_take & sel_evt;
  assign wr_g1 = wr_take & sel_g1;
  assign wr_g2 = wr_take & sel_g2;

  // held at reset value for as long as run enable is low
  always_ff @(posedge mclk) begin
    if (!nrst || !run_q) begin
      evt_sel_q <= ACMC_RST_REG;
      g1_sel_q <= ACMC_RST_REG;
      g2_sel_q <= ACMC_RST_REG;
    end else begin
      if (wr_evt) begin
        evt_sel_q <= merge(evt_sel_q, wd, be);
      end
      if (wr_g1) begin
        g1_sel_q <= merge(g1_sel_q, wd, be);
      end
      if (wr_g2) begin
        g2_sel_q <= merge(g2_sel_q, wd, be);
      end
    end
  end

  // ***************************************************
  // sequencing
  // ***************************************************
  logic ref_req;
  logic in_req;
  acmc_seq_state_t seq_state;

  // level request: covers both a fresh start write and a start bit
  // already standing when calibration is switched on
  assign ref_req = cal_en_q & reference_convert_start_q;
  // a group write or an event on a populated event group; a trigger
  // that lands while the core is busy is dropped, not queued
  assign in_req = !cal_en_q & (wr_g1 | wr_g2 |
                  (conv_event & (evt_sel_q != ACMC_RST_REG)));

  acmc_seq u_seq (
    .mclk(mclk),
    .nrst(nrst),
    .run_en(run_q),
    .clk_stop(clock_stop_q),
    .ref_req(ref_req),
    .in_req(in_req),
    .core_eoc(core_eoc),
    .core_start_q(core_start),
    .ref_done(ref_done),
    .in_done(in_done),
    .state_q(seq_state)
  );

  // ***************************************************
  // status word
  // ***************************************************
  logic [2:0] stat_q;
  logic done_set;
  logic done_clr;

  assign done_set = ref_done | in_done;
  assign done_clr = wr_take & sel_stat & be[0] & wd[ACMC_ST_DONE];

  // done is sticky; an end pulse in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (!nrst || !run_q) begin
      stat_q <= ACMC_RST_STATUS;
    end else begin
      stat_q[ACMC_ST_REF_BUSY] <= (seq_state == ACMC_SEQ_REF);
      stat_q[ACMC_ST_IN_BUSY] <= (seq_state == ACMC_SEQ_INPUT);
      stat_q[ACMC_ST_DONE] <= done_set | (stat_q[ACMC_ST_DONE] & !done_clr);
    end
  end

  // ***************************************************
  // read mux
  // ***************************************************
  always_comb begin
    rdata_d = ACMC_RD_NONE;
    if (sel_ctrl) begin
      rdata_d = {16'h0000, ctrl_w};
    end else if (sel_stat) begin
      rdata_d = {29'h0000_0000, stat_q};
    end else if (sel_evt) begin
      rdata_d = {16'h0000, evt_sel_q};
    end else if (sel_g1) begin
      rdata_d = {16'h0000, g1_sel_q};
    end else if (sel_g2) begin
      rdata_d = {16'h0000, g2_sel_q};
    end
  end

  // captured in the wait cycle, presented at the answering edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_q <= ACMC_RD_NONE;
    end else if (pend && wait_q && av_req.read) begin
      rdata_q <= rdata_d;
    end
  end

  // ***************************************************
  // analog steering
  // ***************************************************
  acmc_route u_route (
    .mclk(mclk),
    .nrst(nrst),
    .cal_en(cal_en_q),
    .test_en(test_q),
    .bridge(bridge_q),
    .pol(pol_q),
    .route_q(route)
  );

  assign av_readdata = rdata_q;
  assign av_waitrequest = wait_q;
  assign clock_stop = clock_stop_q;
endmodule

// ### shared/acmc_pkg.sv
// constants, states and carriers for the converter mode control block
// assumes a 16-bit control register reached over a 32-bit avalon slave
package acmc_pkg;

  // ***************************************************
  // register map (byte addresses)
  // ***************************************************
  localparam int ACMC_AW = 8;
  localparam logic [7:0] ACMC_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACMC_OFS_STATUS = 8'h08;
  localparam logic [7:0] ACMC_OFS_EVT_SEL = 8'h0c;
  localparam logic [7:0] ACMC_OFS_G1_SEL = 8'h10;
  localparam logic [7:0] ACMC_OFS_G2_SEL = 8'h14;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int ACMC_BIT_CAL_EN = 13;
  localparam int ACMC_BIT_REFERENCE_CONVERT_START = 12;
  localparam int ACMC_BIT_BRIDGE = 11;
  localparam int ACMC_BIT_POL = 10;
  localparam int ACMC_BIT_TEST = 9;
  localparam int ACMC_BIT_STOP = 8;
  localparam int ACMC_BIT_RUN = 5;
  localparam int ACMC_ST_REF_BUSY = 0;
  localparam int ACMC_ST_IN_BUSY = 1;
  localparam int ACMC_ST_DONE = 2;
  localparam logic [15:0] ACMC_RST_REG = 16'h0000;
  localparam logic [2:0] ACMC_RST_STATUS = 3'h0;
  localparam logic [31:0] ACMC_RD_NONE = 32'h0000_0000;

  // ***************************************************
  // sequencer states, one-hot
  // ***************************************************
  typedef enum logic [2:0] {
    ACMC_SEQ_IDLE = 3'b001,
    ACMC_SEQ_REF = 3'b010,
    ACMC_SEQ_INPUT = 3'b100
  } acmc_seq_state_t;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [ACMC_AW-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acmc_av_req_t;

  typedef struct packed {
    logic mux_connect;
    logic ref_to_core;
    logic ref_full;
    logic ref_high;
    logic test_inject;
    logic test_high;
  } acmc_route_t;

endpackage

// ### test/acmc_top_assertions.sv
// checker for the converter mode control block ports
// assumes one clock, mclk, and a synchronous active-low nrst
`timescale 1ns/100ps
module acmc_top_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input acmc_pkg::acmc_av_req_t av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire logic core_eoc,
  input wire logic conv_event,
  input wire logic core_start,
  input acmc_pkg::acmc_route_t route,
  input wire logic clock_stop
);
  import acmc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****************
  // routing
  // ****************
  AST_MUX_OFF: assert property (route.mux_connect != route.ref_to_core)
    else $error("mux and reference path clash");
  AST_FULL: assert property (route.ref_full |-> route.ref_to_core)
    else $error("full reference outside calibration");
  AST_POL: assert property (route.ref_high |-> route.ref_to_core)
    else $error("reference polarity outside calibration");
  AST_QUIET: assert property (!route.test_inject |-> !route.test_high)
    else $error("test polarity without self-test");
  AST_TEST: assert property (route.test_inject |-> route.mux_connect)
    else $error("test injection with input mux off");
  // ****************
  // sequencing and bus
  // ****************
  AST_PULSE: assert property (core_start |=> !core_start)
    else $error("start longer than one cycle");
  AST_ONE_CONV: assert property (
    core_start ##1 !core_eoc [*2] |-> !core_start)
    else $error("second start before end of conversion");
  AST_STOPPED: assert property (
    clock_stop && $past(clock_stop) |-> !core_start)
    else $error("start while clocks stopped");
  AST_ANSWER: assert property (
    $rose(av_req.read || av_req.write) |=> !av_waitrequest)
    else $error("bus request not answered in one cycle");
  AST_WAIT_ONE: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than one cycle");
  // main scenarios seen
  cover property (core_start && route.ref_to_core);
  cover property (route.test_inject && route.test_high);
  cover property (clock_stop && !av_waitrequest);
endmodule

bind acmc_top acmc_top_assertions u_chk (.mclk(mclk), .nrst(nrst),
  .av_req(av_req), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .core_eoc(core_eoc),
  .conv_event(conv_event), .core_start(core_start), .route(route),
  .clock_stop(clock_stop));

// ### test/tb.sv
// self-checking bench for the converter mode control block
// assumes the bench plays both bus master and converter core
`timescale 1ns/100ps
module tb;
  import acmc_pkg::*;
  logic mclk, nrst, core_eoc, conv_event, core_start, clock_stop;
  logic av_waitrequest;
  logic [31:0] av_readdata, q, s0, n_start;
  logic [15:0] d, r;
  acmc_av_req_t av_req;
  acmc_route_t route;
  int n_mismatch, total_checks, eoc_lat, eoc_cnt;

  acmc_top u_dut (.mclk(mclk), .nrst(nrst), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .core_eoc(core_eoc), .conv_event(conv_event),
    .core_start(core_start), .route(route), .clock_stop(clock_stop));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // ****************
  // tasks
  // ****************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one avalon cycle; extra edge so the next request rises cleanly
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [15:0] wd);
    av_req.address <= a;
    av_req.writedata <= {16'h0000, wd};
    av_req.byteenable <= 4'hf;
    av_req.write <= wr;
    av_req.read <= ~wr;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge mclk);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge mclk);
  endtask

  // core stand-in: end pulse eoc_lat cycles after each start
  always @(posedge mclk) begin
    core_eoc <= (core_start !== 1'b1) && (eoc_cnt == 1);
    if (core_start === 1'b1) begin
      n_start++;
      eoc_cnt = eoc_lat;
    end else if (eoc_cnt > 0) begin
      eoc_cnt--;
    end
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    tick(20000);
    n_mismatch++;
    summarize();
  end

  // ****************
  // tests
  // ****************
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    core_eoc = 1'b0;
    conv_event = 1'b0;
    av_req = '0;
    n_start = '0;
    eoc_lat = 3;
    eoc_cnt = 0;
    void'($urandom(32'h01611c4c));
    tick(10);
    nrst <= 1'b1;
    tick(2);
    check(32'(route), 32'h20);
    bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
    check(q, 32'h0);
    // selects stay cleared while run is off
    d = 16'($urandom()) | 16'h0001;
    bus(1, ACMC_OFS_G1_SEL, d);
    bus(0, ACMC_OFS_G1_SEL, 16'h0);
    check(q, 32'h0);
    check(n_start, 32'h0);
    // self-test routing and triggers
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0220);
    tick(2);
    check(32'(route), 32'h22);
    bus(1, ACMC_OFS_G1_SEL, d);
    tick(eoc_lat + 2);
    check(n_start, 32'h1);
    bus(0, ACMC_OFS_STATUS, 16'h0);
    check(q, 32'h4);
    bus(1, ACMC_OFS_STATUS, 16'h0004);
    bus(0, ACMC_OFS_STATUS, 16'h0);
    check(q, 32'h0);
    bus(0, ACMC_OFS_G1_SEL, 16'h0);
    check(q, {16'h0, d});
    bus(1, ACMC_OFS_EVT_SEL, d);
    conv_event <= 1'b1;
    @(posedge mclk);
    conv_event <= 1'b0;
    tick(eoc_lat + 2);
    check(n_start, 32'h2);
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0620);
    tick(2);
    check(32'(route), 32'h23);
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0420);
    tick(2);
    check(32'(route), 32'h20);
    // start bit set before calibration is on
    eoc_lat = 20;
    bus(1, ACMC_OFS_CTRL_ONE, 16'h1020);
    check(n_start, 32'h2);
    bus(1, ACMC_OFS_CTRL_ONE, 16'h2020);
    tick(2);
    check(n_start, 32'h3);
    bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
    check(q, 32'h3020);
    bus(0, ACMC_OFS_STATUS, 16'h0);
    check(q, 32'h5);
    tick(eoc_lat);
    // every bridge and polarity pair
    for (int i = 0; i < 4; i++) begin
      d = 16'h2020 | (16'(i) << 10);
      bus(1, ACMC_OFS_CTRL_ONE, d);
      s0 = n_start;
      bus(1, ACMC_OFS_CTRL_ONE, d | 16'h1000);
      tick(2);
      check(n_start, s0 + 1);
      check(32'(route), 32'h10 | (32'(i) << 2));
      bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
      check(q, {16'h0, d | 16'h1000});
      tick(eoc_lat);
      bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
      check(q, {16'h0, d});
    end
    // reserved bits and an unmapped place
    r = 16'($urandom()) & 16'hccff | 16'h0020;
    bus(1, ACMC_OFS_CTRL_ONE, r);
    bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
    check(q, {16'h0, r & 16'h0c20});
    bus(1, 8'h04, r);
    bus(0, 8'h04, 16'h0);
    check(q, 32'h0);
    // power-down fences the selects
    s0 = n_start;
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0120);
    tick(2);
    check(32'(clock_stop), 32'h1);
    bus(1, ACMC_OFS_G2_SEL, r | 16'h0001);
    bus(0, ACMC_OFS_G2_SEL, 16'h0);
    check(q, 32'h0);
    check(n_start, s0);
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0020);
    tick(2);
    check(32'(clock_stop), 32'h0);
    bus(0, ACMC_OFS_G2_SEL, 16'h0);
    check(q, 32'h0);
    // run off clears selects and status
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0);
    bus(0, ACMC_OFS_EVT_SEL, 16'h0);
    check(q, 32'h0);
    bus(0, ACMC_OFS_STATUS, 16'h0);
    check(q, 32'h0);
    // mid-run reset clears run enable again
    bus(1, ACMC_OFS_CTRL_ONE, 16'h0020);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(2);
    bus(0, ACMC_OFS_CTRL_ONE, 16'h0);
    check(q, 32'h0);
    summarize();
  end
endmodule
